// File: rtl/bic_consts.svh
/*
 Constants of the bus interface option control block: field positions
 of the bus configuration word, its reset value and the timing counts.
 Assumes inclusion by the design file only.
*/
`ifndef BIC_CONSTS_SVH
`define BIC_CONSTS_SVH
`define BIC_STB_LSB 0
`define BIC_EXB_LSB 2
`define BIC_TURN_LSB 4
`define BIC_BE16_BIT 6
`define BIC_BE_BIT 7
`define BIC_DMA_BIT 8
`define BIC_TC_BIT 9
`define BIC_BR_BIT 10
`define BIC_LOCK_BIT 31
`define BIC_CFG_RESET 32'h0000_00FF
`define BIC_TC_LAG 2
`define BIC_TC_PULSE 2
`endif

// File: rtl/bic_option_ctrl.sv
/*
 Bus interface option control: the bus configuration word, lane select
 read masking, strobe pin modes, bus turnaround spacing, bus grant
 protocol towards an external master and the terminal count waveform.
 Assumes the bus unit presents transfers as one-cycle-registered
 requests, and the timer outside flags each count/compare match.
*/
`timescale 1ns/1ps
`include "bic_consts.svh"

module bic_option_ctrl
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cfg_wr,
	input wire logic [31:0] cfg_wr_data,
	output logic [31:0] cfg_rd_data,
	input wire logic cmp_wr,
	input wire logic count_match,
	output logic terminal_count_out_n,
	input wire bic_pkg::bic_xfer_t xfer,
	output logic [3:0] byte_lane_selects_n,
	output logic [1:0] halfword_lane_selects_n,
	input wire logic rd_data_sampled,
	output logic addr_drive_ok,
	input wire logic bus_request_in_n,
	input wire logic reclaim_req,
	output logic bus_grant_out_n,
	output logic cpu_owns_bus,
	input wire logic [1:0] upper_branch_condition_pins_in,
	output logic [1:0] upper_branch_condition_pins_out,
	output logic [1:0] upper_branch_condition_pins_oe,
	output logic [1:0] branch_conditions
);
	import bic_pkg::*;

	bic_state_t st_reg;
	bic_state_t st_next;

	// Word to fields; reserved bits are dropped
	function automatic bic_cfg_t word_to_cfg(input logic [31:0] w);
		bic_cfg_t c;
		c.lock = w[`BIC_LOCK_BIT];
		c.br_mode = w[`BIC_BR_BIT];
		c.tc_mode = w[`BIC_TC_BIT];
		c.dma_pulse = w[`BIC_DMA_BIT];
		c.be_ctl = w[`BIC_BE_BIT];
		c.be16_ctl = w[`BIC_BE16_BIT];
		c.turn = w[`BIC_TURN_LSB +: 2];
		c.exb_mode = w[`BIC_EXB_LSB +: 2];
		c.stb_mode = w[`BIC_STB_LSB +: 2];
		return c;
	endfunction

	// Fields to word; reserved bits read zero
	function automatic logic [31:0] cfg_to_word(input bic_cfg_t c);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`BIC_LOCK_BIT] = c.lock;
		w[`BIC_BR_BIT] = c.br_mode;
		w[`BIC_TC_BIT] = c.tc_mode;
		w[`BIC_DMA_BIT] = c.dma_pulse;
		w[`BIC_BE_BIT] = c.be_ctl;
		w[`BIC_BE16_BIT] = c.be16_ctl;
		w[`BIC_TURN_LSB +: 2] = c.turn;
		w[`BIC_EXB_LSB +: 2] = c.exb_mode;
		w[`BIC_STB_LSB +: 2] = c.stb_mode;
		return w;
	endfunction

	// Strobe mode decode: bit 0 enables writes, bit 1 enables reads
	function automatic logic mode_hits(input logic [1:0] mode, input logic rd);
		return rd ? mode[1] : mode[0];
	endfunction

	// Next state of the whole block
	always_comb
	begin
		st_next = st_reg;

		// Configuration word, frozen once locked
		if (cfg_wr && !st_reg.cfg.lock)
		begin
			st_next.cfg = word_to_cfg(cfg_wr_data);
		end

		// Pin synchronisers; a change counts once stages two and three agree
		st_next.brq_s = {st_reg.brq_s[1:0], bus_request_in_n};
		if (st_reg.brq_s[1] == st_reg.brq_s[2])
		begin
			st_next.brq_f = st_reg.brq_s[2];
		end
		st_next.brc_s1 = upper_branch_condition_pins_in;
		st_next.brc_s2 = st_reg.brc_s1;
		st_next.brc_s3 = st_reg.brc_s2;
		if (st_reg.brc_s2 == st_reg.brc_s3)
		begin
			st_next.brc_f = st_reg.brc_s3;
		end

		// Lane selects, masked on reads when the control bits are clear
		st_next.be_n = 4'hF;
		st_next.be16_n = 2'h3;
		if (xfer.active && (!xfer.read || st_reg.cfg.be_ctl))
		begin
			st_next.be_n = ~xfer.lanes;
		end
		if (xfer.active && (!xfer.read || st_reg.cfg.be16_ctl))
		begin
			st_next.be16_n = ~xfer.halves;
		end

		// Strobes only exist while the upper pins are outputs
		st_next.stb_n = 1'b1;
		st_next.exb_n = 1'b1;
		if (xfer.active && st_reg.cfg.br_mode)
		begin
			st_next.stb_n = !mode_hits(st_reg.cfg.stb_mode, xfer.read);
			st_next.exb_n = !mode_hits(st_reg.cfg.exb_mode, xfer.read);
		end

		// Turnaround: whole extra cycles before the address may go out
		if (rd_data_sampled)
		begin
			st_next.ta_cnt = st_reg.cfg.turn;
		end
		else if (st_reg.ta_cnt != 2'h0)
		begin
			st_next.ta_cnt = st_reg.ta_cnt - 2'h1;
		end

		// Bus ownership towards the external master
		unique case (st_reg.dma)
			BIC_IDLE:
			begin
				if (!st_reg.brq_f)
				begin
					st_next.dma = BIC_GRANT;
					st_next.bgnt_n = 1'b0;
				end
			end
			BIC_GRANT:
			begin
				if (st_reg.brq_f)
				begin
					st_next.dma = BIC_IDLE;
					st_next.bgnt_n = 1'b1;
				end
				else if (st_reg.cfg.dma_pulse && reclaim_req)
				begin
					st_next.dma = BIC_RECLAIM;
					st_next.bgnt_n = 1'b1;
				end
			end
			BIC_RECLAIM:
			begin
				// Master still owns the bus until it drops its request
				if (st_reg.brq_f)
				begin
					st_next.dma = BIC_IDLE;
				end
			end
		endcase

		// Terminal count: a match reaches the pin two edges later
		st_next.tc_pipe = {st_reg.tc_pipe[0], count_match};
		if (st_reg.tc_pipe[`BIC_TC_LAG - 2])
		begin
			// Assertion wins over a coincident compare rewrite
			st_next.tc_n = 1'b0;
			st_next.tc_cnt = 2'(`BIC_TC_PULSE - 1);
		end
		else if (!st_reg.tc_n && !st_reg.cfg.tc_mode)
		begin
			if (st_reg.tc_cnt == 2'h0)
			begin
				st_next.tc_n = 1'b1;
			end
			else
			begin
				st_next.tc_cnt = st_reg.tc_cnt - 2'h1;
			end
		end
		else if (!st_reg.tc_n && cmp_wr)
		begin
			st_next.tc_n = 1'b1;
		end
	end

	// Single state register
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg <= '0;
			st_reg.cfg <= word_to_cfg(`BIC_CFG_RESET);
			st_reg.dma <= BIC_IDLE;
			st_reg.bgnt_n <= 1'b1;
			st_reg.brq_s <= 3'h7;
			st_reg.brq_f <= 1'b1;
			st_reg.tc_n <= 1'b1;
			st_reg.be_n <= 4'hF;
			st_reg.be16_n <= 2'h3;
			st_reg.stb_n <= 1'b1;
			st_reg.exb_n <= 1'b1;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state
	assign cfg_rd_data = cfg_to_word(st_reg.cfg);
	assign terminal_count_out_n = st_reg.tc_n;
	assign byte_lane_selects_n = st_reg.be_n;
	assign halfword_lane_selects_n = st_reg.be16_n;
	assign addr_drive_ok = (st_reg.ta_cnt == 2'h0);
	assign bus_grant_out_n = st_reg.bgnt_n;
	assign cpu_owns_bus = (st_reg.dma == BIC_IDLE);
	assign branch_conditions = st_reg.brc_f;

	// Pin three carries the strobe, pin two the buffer enable
	assign upper_branch_condition_pins_out = {st_reg.stb_n, st_reg.exb_n};
	assign upper_branch_condition_pins_oe = {2{st_reg.cfg.br_mode}};

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	// Strobe pins stay quiet while they are inputs; enables follow the mode bit at once
	property p_pins_in_quiet;
		!st_reg.cfg.br_mode |-> upper_branch_condition_pins_oe == 2'h0
			##1 st_reg.stb_n && st_reg.exb_n;
	endproperty
	a_pins_in_quiet: assert property (p_pins_in_quiet)
		else $error("strobe active with pins as inputs");
	property p_stb_write_only;
		xfer.active && st_reg.cfg.br_mode && st_reg.cfg.stb_mode == 2'h1
			|=> st_reg.stb_n == $past(xfer.read);
	endproperty
	a_stb_write_only: assert property (p_stb_write_only)
		else $error("strobe write-only mode wrong");
	property p_exb_read_only;
		xfer.active && st_reg.cfg.br_mode && st_reg.cfg.exb_mode == 2'h2
			|=> upper_branch_condition_pins_out[0] == !$past(xfer.read);
	endproperty
	a_exb_read_only: assert property (p_exb_read_only)
		else $error("buffer enable read-only wrong");
	property p_be16_mask;
		xfer.active && xfer.read && !st_reg.cfg.be16_ctl
			|=> halfword_lane_selects_n == 2'h3;
	endproperty
	a_be16_mask: assert property (p_be16_mask)
		else $error("halfword select on masked read");
	property p_be16_live;
		xfer.active && st_reg.cfg.be16_ctl
			|=> halfword_lane_selects_n == ~$past(xfer.halves);
	endproperty
	a_be16_live: assert property (p_be16_live)
		else $error("halfword select not sized");
	property p_be_mask;
		xfer.active && xfer.read && !st_reg.cfg.be_ctl |=> byte_lane_selects_n == 4'hF;
	endproperty
	a_be_mask: assert property (p_be_mask)
		else $error("byte select on masked read");
	property p_be_write;
		xfer.active && !xfer.read |=> byte_lane_selects_n == ~$past(xfer.lanes);
	endproperty
	a_be_write: assert property (p_be_write)
		else $error("byte select not sized on write");
	// Longest spacing: three blocked edges after the sample, free on the fourth
	property p_turn_max;
		rd_data_sampled && st_reg.cfg.turn == 2'h3 ##1 !rd_data_sampled [*3]
			|-> !addr_drive_ok && !$past(addr_drive_ok) && !$past(addr_drive_ok, 2)
			##1 addr_drive_ok;
	endproperty
	a_turn_max: assert property (p_turn_max)
		else $error("turnaround of three cycles wrong");
	property p_turn_min;
		rd_data_sampled && st_reg.cfg.turn == 2'h0 |=> addr_drive_ok;
	endproperty
	a_turn_min: assert property (p_turn_min)
		else $error("turnaround of zero cycles wrong");
	property p_grant_held;
		st_reg.dma == BIC_GRANT && !st_reg.cfg.dma_pulse && !st_reg.brq_f
			|=> !bus_grant_out_n;
	endproperty
	a_grant_held: assert property (p_grant_held)
		else $error("grant dropped in plain mode");
	property p_reclaim_wait;
		st_reg.dma == BIC_RECLAIM && !st_reg.brq_f |-> bus_grant_out_n ##1 !cpu_owns_bus;
	endproperty
	a_reclaim_wait: assert property (p_reclaim_wait)
		else $error("bus taken before request drop");
	property p_tc_lag;
		count_match |-> ##2 !terminal_count_out_n;
	endproperty
	a_tc_lag: assert property (p_tc_lag)
		else $error("terminal count not two cycles after match");
	sequence s_tc_pulse;
		!terminal_count_out_n ##1 terminal_count_out_n;
	endsequence
	property p_tc_pulse;
		$fell(terminal_count_out_n) && !st_reg.cfg.tc_mode && !cfg_wr && !count_match
			|=> s_tc_pulse;
	endproperty
	a_tc_pulse: assert property (p_tc_pulse)
		else $error("terminal count pulse length wrong");
	property p_tc_hold;
		!terminal_count_out_n && st_reg.cfg.tc_mode && !cmp_wr |=> !terminal_count_out_n;
	endproperty
	a_tc_hold: assert property (p_tc_hold)
		else $error("terminal count left without rewrite");
	property p_lock;
		st_reg.cfg.lock |=> $stable(cfg_rd_data);
	endproperty
	a_lock: assert property (p_lock)
		else $error("locked configuration changed");
endmodule

// File: rtl/bic_pkg.sv
/*
 Types of the bus interface option control block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package bic_pkg;
	// Ownership of the shared bus towards an external master
	typedef enum logic [1:0] {BIC_IDLE, BIC_GRANT, BIC_RECLAIM} bic_dma_t;

	// Decoded bus configuration word
	typedef struct packed {
		logic lock;
		logic br_mode;
		logic tc_mode;
		logic dma_pulse;
		logic be_ctl;
		logic be16_ctl;
		logic [1:0] turn;
		logic [1:0] exb_mode;
		logic [1:0] stb_mode;
	} bic_cfg_t;

	// One transfer as the bus unit presents it; lanes active high
	typedef struct packed {
		logic active;
		logic read;
		logic [3:0] lanes;
		logic [1:0] halves;
	} bic_xfer_t;

	// Whole state of the block
	typedef struct packed {
		bic_cfg_t cfg;
		bic_dma_t dma;
		logic bgnt_n;
		logic [2:0] brq_s;
		logic brq_f;
		logic [1:0] brc_s1;
		logic [1:0] brc_s2;
		logic [1:0] brc_s3;
		logic [1:0] brc_f;
		logic [1:0] ta_cnt;
		logic [1:0] tc_pipe;
		logic tc_n;
		logic [1:0] tc_cnt;
		logic [3:0] be_n;
		logic [1:0] be16_n;
		logic stb_n;
		logic exb_n;
	} bic_state_t;
endpackage

// File: sim/bic_dma_master.sv
/*
 External bus master model: requests the bus, gives it back after a
 lag once the grant is taken away. Assumes drive at the falling edge.
*/
`timescale 1ns/1ps

module bic_dma_master
(
	input wire logic clk_sys,
	input wire logic want,
	input wire logic [3:0] lag,
	input wire logic bus_grant_out_n,
	output logic bus_request_in_n
);
	logic granted = 1'b0;
	logic [3:0] wait_cnt = 4'h0;

	initial bus_request_in_n = 1'b1;

	// Request once per tenure; no re-request after handing the bus back
	always @(negedge clk_sys)
	begin
		if (!want)
		begin
			bus_request_in_n <= 1'b1;
			granted <= 1'b0;
			wait_cnt <= 4'h0;
		end
		else if (!granted)
		begin
			bus_request_in_n <= 1'b0;
			granted <= !bus_grant_out_n;
		end
		else if (bus_grant_out_n && !bus_request_in_n)
		begin
			// Slow release keeps the reclaim window visible
			wait_cnt <= wait_cnt + 4'h1;
			if (wait_cnt == lag)
				bus_request_in_n <= 1'b1;
		end
	end
endmodule

// File: sim/tb.sv
/*
 Testbench of the bus interface option control block.
 Assumes the block and the bus master model; drives at falling edges.
*/
`timescale 1ns/1ps

module tb;
	import bic_pkg::*;
	logic clk_sys, rst_n, cfg_wr, cmp_wr, count_match, tc_n, rd_data_sampled;
	logic [31:0] cfg_wr_data, cfg_rd_data;
	bic_xfer_t xfer;
	logic [3:0] be_n;
	logic [1:0] be16_n, pins_in, pins_out, pins_oe, branch_conditions, bc_drv;
	logic addr_drive_ok, req_n, reclaim_req, grant_n, cpu_owns_bus, want;
	int n_mismatch, checks_done, m, cnt;
	logic [4:0] pat;

	// Shared pin level: whoever enables drives
	assign pins_in = (pins_oe & pins_out) | (~pins_oe & bc_drv);

	bic_option_ctrl bic_option_ctrl_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.cfg_wr(cfg_wr), .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data),
		.cmp_wr(cmp_wr), .count_match(count_match), .terminal_count_out_n(tc_n),
		.xfer(xfer), .byte_lane_selects_n(be_n), .halfword_lane_selects_n(be16_n),
		.rd_data_sampled(rd_data_sampled), .addr_drive_ok(addr_drive_ok),
		.bus_request_in_n(req_n), .reclaim_req(reclaim_req),
		.bus_grant_out_n(grant_n), .cpu_owns_bus(cpu_owns_bus),
		.upper_branch_condition_pins_in(pins_in),
		.upper_branch_condition_pins_out(pins_out),
		.upper_branch_condition_pins_oe(pins_oe),
		.branch_conditions(branch_conditions));

	bic_dma_master bic_dma_master_inst (.clk_sys(clk_sys), .want(want), .lag(4'h6),
		.bus_grant_out_n(grant_n), .bus_request_in_n(req_n));

	task tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %s exp %h seen %h", name, exp, seen);
		end
	endtask

	// One accepted write shows up after the next edge; an idle edge follows
	// so that back-to-back calls never lower and raise the strobe at once
	task wcfg(input logic [31:0] d);
		cfg_wr = 1'b1;
		cfg_wr_data = d;
		tick(1);
		cfg_wr = 1'b0;
		tick(1);
	endtask

	// Transfer stays presented until the next call or an explicit clear
	task xf(input logic rd, input logic [3:0] ln, input logic [1:0] hv);
		xfer = '{1'b1, rd, ln, hv};
		tick(1);
	endtask

	task summarize;
		if (n_mismatch == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Free-running system clock, 25 ns
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// Cuts a hang short
	initial
	begin
		#(25 * 4000);
		n_mismatch++;
		summarize();
	end

	// Main sequence
	initial
	begin
		rst_n = 1'b0;
		{cfg_wr, cmp_wr, count_match, rd_data_sampled, reclaim_req, want} = '0;
		cfg_wr_data = 32'h0;
		xfer = '0;
		bc_drv = 2'h2;
		tick(6);
		rst_n = 1'b1;
		chk("cfg", cfg_rd_data, 32'h000000FF);
		tick(6);
		chk("brc", branch_conditions, 2'h2);
		chk("oe", pins_oe, 2'h0);
		xf(1'b1, 4'h3, 2'h1);
		chk("be", be_n, 4'hC);
		chk("be16", be16_n, 2'h2);
		chk("pins", pins_out, 2'h3);
		wcfg(32'h0000003F);
		xf(1'b1, 4'hF, 2'h3);
		chk("be", be_n, 4'hF);
		chk("be16", be16_n, 2'h3);
		xf(1'b0, 4'h3, 2'h1);
		chk("be", be_n, 4'hC);
		chk("be16", be16_n, 2'h2);
		// Every strobe and buffer enable code on reads and writes
		for (m = 0; m < 4; m++)
		begin
			wcfg(32'h000004F0 | m | (m << 2));
			chk("oe", pins_oe, 2'h3);
			xf(1'b1, 4'hF, 2'h3);
			chk("pins rd", pins_out, {2{~m[1]}});
			xf(1'b0, 4'hF, 2'h3);
			chk("pins wr", pins_out, {2{~m[0]}});
		end
		xfer = '0;
		// Turnaround spacing for every code
		for (m = 0; m < 4; m++)
		begin
			wcfg(32'h000000CF | (m << 4));
			rd_data_sampled = 1'b1;
			tick(1);
			rd_data_sampled = 1'b0;
			cnt = 0;
			while (addr_drive_ok !== 1'b1 && cnt < 8)
			begin
				cnt++;
				tick(1);
			end
			chk("turn", cnt, m);
		end
		// Terminal count, pulse then software acknowledge
		wcfg(32'h000000FF);
		for (m = 0; m < 2; m++)
		begin
			pat = m ? 5'b10000 : 5'b10011;
			count_match = 1'b1;
			tick(1);
			count_match = 1'b0;
			for (cnt = 4; cnt >= 0; cnt--)
			begin
				chk("tc", tc_n, pat[cnt]);
				tick(1);
			end
			wcfg(32'h000002FF);
		end
		tick(6);
		chk("tc held", tc_n, 1'b0);
		cmp_wr = 1'b1;
		tick(1);
		cmp_wr = 1'b0;
		tick(1);
		chk("tc ack", tc_n, 1'b1);
		// External master tenure
		wcfg(32'h000000FF);
		want = 1'b1;
		cnt = 0;
		while (grant_n !== 1'b0 && cnt < 12)
		begin
			cnt++;
			tick(1);
		end
		chk("gnt", grant_n, 1'b0);
		reclaim_req = 1'b1;
		tick(10);
		chk("gnt held", grant_n, 1'b0);
		wcfg(32'h000001FF);
		cnt = 0;
		while (grant_n !== 1'b1 && cnt < 8)
		begin
			cnt++;
			tick(1);
		end
		chk("gnt drop", grant_n, 1'b1);
		chk("own early", cpu_owns_bus, 1'b0);
		cnt = 0;
		while (cpu_owns_bus !== 1'b1 && cnt < 20)
		begin
			cnt++;
			tick(1);
		end
		chk("own", cpu_owns_bus, 1'b1);
		reclaim_req = 1'b0;
		want = 1'b0;
		// Lock freezes the word
		wcfg(32'h800000FF);
		chk("lock", cfg_rd_data, 32'h800000FF);
		wcfg(32'h00000000);
		chk("locked", cfg_rd_data, 32'h800000FF);
		summarize();
	end
endmodule
